// File: scs_pkg.sv
// constants and types shared by the serial configuration sequencer
package scs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ            = 100;
  localparam int CF2CD_NS           = 1440;
  localparam int CF2ST0_NS          = 960;
  localparam int CF2CD_CYC          = (CF2CD_NS * CLK_MHZ) / 1000;
  localparam int CF2ST0_CYC         = (CF2ST0_NS * CLK_MHZ) / 1000;
  localparam int STATUS_MIN_US      = 268;
  localparam int STATUS_MAX_US      = 3000;
  localparam int STATUS_MIN_CYC     = STATUS_MIN_US * CLK_MHZ;
  localparam int STATUS_MAX_CYC     = STATUS_MAX_US * CLK_MHZ;
  localparam int CD2UM_MIN_US       = 175;
  localparam int CD2UM_MAX_US       = 830;
  localparam int CD2UM_MIN_CYC      = CD2UM_MIN_US * CLK_MHZ;
  localparam int INIT_CYCLES        = 600;
  localparam int CD2CU_PERIODS      = 4;
  localparam int OSC_DIV            = 8;
  localparam int OSC_INIT_CYC       = INIT_CYCLES * OSC_DIV;
  localparam int CD2CU_CYC          = CD2CU_PERIODS * OSC_DIV;

  // ****************************************
  // clock settings, dividers, states
  // ****************************************
  typedef enum logic [1:0] {
    SCS_CLK_12M5 = 2'h0,
    SCS_CLK_25M  = 2'h1,
    SCS_CLK_50M  = 2'h2,
    SCS_CLK_100M = 2'h3
  } scs_clk_sel_t;

  localparam logic [5:0] DIV_12M5 = 6'h07;
  localparam logic [5:0] DIV_25M  = 6'h03;
  localparam logic [5:0] DIV_50M  = 6'h01;
  localparam logic [5:0] DIV_100M = 6'h00;

  typedef enum logic [4:0] {
    SCS_RESET = 5'h01,
    SCS_WAIT  = 5'h02,
    SCS_RECV  = 5'h04,
    SCS_INIT  = 5'h08,
    SCS_USER  = 5'h10
  } scs_state_t;

  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;

  function automatic logic [5:0] scs_half_div(input scs_clk_sel_t s, input logic chained);
    logic [5:0] d;
    d = DIV_12M5;
    case (s)
      SCS_CLK_12M5: d = DIV_12M5;
      SCS_CLK_25M:  d = DIV_25M;
      SCS_CLK_50M:  d = DIV_50M;
      SCS_CLK_100M: d = chained ? DIV_50M : DIV_100M;
    endcase
    return d;
  endfunction : scs_half_div

endpackage : scs_pkg

// File: scs_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module scs_sync
  import scs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      q     <= 1'b1;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        q <= s3_ff;
    end
  end
endmodule : scs_sync
`default_nettype wire

// File: scs_fifo.sv
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module scs_fifo
  import scs_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  output var  logic [W-1:0] out_data,
  output var  logic         out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else if (flush)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= AW'(wr_ff + 1'b1);
      if (pop)
        rd_ff <= AW'(rd_ff + 1'b1);
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!rst_n)
    (!in_ready && !flush) |=> wr_ff == $past(wr_ff))
    else $error("fifo write pointer moved while full");
endmodule : scs_fifo
`default_nettype wire

// File: scs_top.sv
// serial configuration sequencer top: reset handshake, data path, initialization
`timescale 1ns/100ps
`default_nettype none
module scs_top
  import scs_pkg::*;
#(
  parameter int STATUS_CYC     = STATUS_MIN_CYC,
  parameter int CD2UM_CYC      = CD2UM_MIN_CYC
)
(
  input  wire logic       MCLK,
  input  wire logic       NRST,
  input  wire logic       CFG_REQ_N,
  input  wire logic       STATUS_N_IN,
  output var  logic       STATUS_N_OE,
  output logic            STATUS_N_OUT,
  output var  logic       CONF_DONE,
  output var  logic       USER_MODE,
  input  wire logic       ACTIVE_SERIAL_SCHEME,
  input  wire logic       USER_INIT_CLOCK_EN,
  input  wire logic       CHAINED,
  input  wire logic [1:0] CLK_SEL,
  input  wire logic       CONFIG_CLOCK_IN,
  output var  logic       CONFIG_CLOCK_OUT,
  output var  logic       CONFIG_CLOCK_OE,
  input  wire logic       CONFIG_DATA_IN,
  output var  logic       FLASH_COMMAND_OUT,
  input  wire logic       USER_INIT_CLOCK,
  output var  logic       USER_INIT_CLOCK_ENABLED,
  input  wire logic [7:0] CMD_DATA,
  input  wire logic       CMD_VALID,
  output logic            CMD_READY,
  input  wire logic       LOAD_DONE,
  output var  logic [7:0] CFG_BYTE,
  output logic            CFG_BYTE_VALID,
  input  wire logic       CFG_BYTE_READY
);

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic       rst_a_ff;
  logic       rst_n;
  logic       req_n_s;
  logic       stat_n_s;
  logic       cclk_s;
  logic       cdat_s;
  logic       uclk_s;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_a_ff <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_n    <= rst_a_ff;
    end
  end

  scs_sync u_req  (.clk(MCLK), .rst_n(rst_n), .d(CFG_REQ_N),       .q(req_n_s));
  scs_sync u_stat (.clk(MCLK), .rst_n(rst_n), .d(STATUS_N_IN),     .q(stat_n_s));
  scs_sync u_cclk (.clk(MCLK), .rst_n(rst_n), .d(CONFIG_CLOCK_IN), .q(cclk_s));
  scs_sync u_cdat (.clk(MCLK), .rst_n(rst_n), .d(CONFIG_DATA_IN),  .q(cdat_s));
  scs_sync u_uclk (.clk(MCLK), .rst_n(rst_n), .d(USER_INIT_CLOCK), .q(uclk_s));

  // ****************************************
  // sequencing state machine
  // ****************************************
  scs_state_t state_ff;
  scs_state_t nxt_state;
  logic [31:0] tmr_ff;
  logic [9:0]  init_cnt_ff;
  logic        init_tick;
  logic        uclk_d_ff;
  logic        osc_tick;
  logic [2:0]  osc_ff;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SCS_RESET: if (tmr_ff >= 32'(STATUS_CYC) && req_n_s) nxt_state = SCS_WAIT;
      SCS_WAIT:  if (stat_n_s) nxt_state = SCS_RECV;
      SCS_RECV:  if (LOAD_DONE) nxt_state = SCS_INIT;
      SCS_INIT:  if (init_cnt_ff == 10'(INIT_CYCLES)) nxt_state = SCS_USER;
      SCS_USER:  nxt_state = SCS_USER;
      default:   nxt_state = SCS_RESET;
    endcase
    if (!req_n_s)
      nxt_state = SCS_RESET;
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= SCS_RESET;
    else
      state_ff <= nxt_state;
  end

  // one timer serves the status low width and the init delay
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      tmr_ff <= 32'h00000000;
    else if (nxt_state != state_ff)
      tmr_ff <= 32'h00000000;
    else if (tmr_ff != 32'hFFFFFFFF)
      tmr_ff <= tmr_ff + 32'h00000001;
  end

  // ****************************************
  // status and done pins
  // ****************************************
  assign STATUS_N_OUT = 1'b0;

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      STATUS_N_OE <= 1'b1;
      CONF_DONE   <= 1'b0;
      USER_MODE   <= 1'b0;
    end
    else
    begin
      STATUS_N_OE <= (nxt_state == SCS_RESET);
      CONF_DONE   <= (nxt_state == SCS_INIT) || (nxt_state == SCS_USER);
      USER_MODE   <= (nxt_state == SCS_USER);
    end
  end

  // ****************************************
  // initialization clock: internal divider or user clock
  // ****************************************
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_ff    <= 3'h0;
      uclk_d_ff <= 1'b0;
    end
    else
    begin
      osc_ff    <= 3'(osc_ff + 3'h1);
      uclk_d_ff <= uclk_s;
    end
  end
  assign osc_tick = (osc_ff == 3'h7);

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      USER_INIT_CLOCK_ENABLED <= 1'b0;
    else
      USER_INIT_CLOCK_ENABLED <= USER_INIT_CLOCK_EN && state_ff == SCS_INIT
                                 && tmr_ff >= 32'(CD2CU_CYC);
  end

  // oscillator ticks are held off until CD2UM_CYC - OSC_INIT_CYC + OSC_DIV cycles, so the last tick lands at or after the minimum user-mode delay
  assign init_tick = USER_INIT_CLOCK_EN ? (USER_INIT_CLOCK_ENABLED && uclk_s && !uclk_d_ff)
                                        : (osc_tick && tmr_ff >= 32'(CD2UM_CYC - OSC_INIT_CYC + OSC_DIV));

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      init_cnt_ff <= 10'h000;
    else if (state_ff != SCS_INIT)
      init_cnt_ff <= 10'h000;
    else if (init_tick && init_cnt_ff != 10'(INIT_CYCLES))
      init_cnt_ff <= 10'(init_cnt_ff + 10'h001);
  end

  // ****************************************
  // configuration clock generation and data path
  // ****************************************
  logic [5:0] div_ff;
  logic       cclk_d_ff;
  logic       as_fall;
  logic       ps_rise;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic       byte_vld_ff;
  logic [7:0] cmd_sh_ff;
  logic [2:0] cmd_bits_ff;
  logic       in_ready;
  logic       recv;

  assign recv    = (state_ff == SCS_RECV);
  assign as_fall = ACTIVE_SERIAL_SCHEME && recv && CONFIG_CLOCK_OUT
                   && div_ff >= scs_half_div(scs_clk_sel_t'(CLK_SEL), CHAINED) && in_ready;
  assign ps_rise = !ACTIVE_SERIAL_SCHEME && recv && cclk_s && !cclk_d_ff;

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff           <= 6'h00;
      CONFIG_CLOCK_OUT <= 1'b0;
      CONFIG_CLOCK_OE  <= 1'b0;
      cclk_d_ff        <= 1'b0;
    end
    else
    begin
      cclk_d_ff       <= cclk_s;
      CONFIG_CLOCK_OE <= ACTIVE_SERIAL_SCHEME && recv;
      if (!(ACTIVE_SERIAL_SCHEME && recv))
      begin
        div_ff           <= 6'h00;
        CONFIG_CLOCK_OUT <= 1'b0;
      end
      // a faster setting chosen mid-count takes effect at once instead of wrapping
      else if (div_ff >= scs_half_div(scs_clk_sel_t'(CLK_SEL), CHAINED))
      begin
        div_ff <= 6'h00;
        // clock stalls low-going while the fifo is full
        if (in_ready || !CONFIG_CLOCK_OUT)
          CONFIG_CLOCK_OUT <= !CONFIG_CLOCK_OUT;
      end
      else
        div_ff <= 6'(div_ff + 6'h01);
    end
  end

  // command bits shift out on the falling edge we generate
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_sh_ff         <= 8'h00;
      cmd_bits_ff       <= 3'h0;
      FLASH_COMMAND_OUT <= 1'b0;
    end
    else if (CMD_READY && CMD_VALID)
    begin
      cmd_sh_ff   <= CMD_DATA;
      cmd_bits_ff <= 3'h7;
    end
    // a command cut by a restart is dropped, not resumed
    else if (!recv)
      cmd_bits_ff <= 3'h0;
    else if (as_fall)
    begin
      FLASH_COMMAND_OUT <= cmd_sh_ff[7];
      cmd_sh_ff         <= {cmd_sh_ff[6:0], 1'b0};
      if (cmd_bits_ff != 3'h0)
        cmd_bits_ff <= 3'(cmd_bits_ff - 3'h1);
    end
  end
  assign CMD_READY = recv && ACTIVE_SERIAL_SCHEME && cmd_bits_ff == 3'h0;

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_ff       <= 8'h00;
      bit_ff      <= 3'h0;
      byte_vld_ff <= 1'b0;
    end
    else
    begin
      if (byte_vld_ff && in_ready)
        byte_vld_ff <= 1'b0;
      if (!recv)
        bit_ff <= 3'h0;
      else if (as_fall || ps_rise)
      begin
        sh_ff  <= {sh_ff[6:0], cdat_s};
        bit_ff <= 3'(bit_ff + 3'h1);
        if (bit_ff == 3'h7)
          byte_vld_ff <= 1'b1;
      end
    end
  end

  scs_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk      (MCLK),
    .rst_n    (rst_n),
    .flush    (state_ff == SCS_RESET),
    .in_data  (sh_ff),
    .in_valid (byte_vld_ff),
    .in_ready (in_ready),
    .out_data (CFG_BYTE),
    .out_valid(CFG_BYTE_VALID),
    .out_ready(CFG_BYTE_READY)
  );

  // ****************************************
  // checks
  // ****************************************
  a_done_drop: assert property (@(posedge MCLK) disable iff (!rst_n)
    $fell(req_n_s) |-> ##[1:2] !CONF_DONE)
    else $error("config done not low after request");
  a_status_drop: assert property (@(posedge MCLK) disable iff (!rst_n)
    $fell(req_n_s) |-> ##1 STATUS_N_OE)
    else $error("status not driven low");
  a_status_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_ff == SCS_RESET && tmr_ff < 32'(STATUS_CYC)) |-> ##1 STATUS_N_OE)
    else $error("status released early");
  a_user_order: assert property (@(posedge MCLK) disable iff (!rst_n)
    $rose(USER_MODE) |-> CONF_DONE && $past(state_ff) == SCS_INIT)
    else $error("user mode without init");
  a_init_count: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_ff == SCS_USER && $past(state_ff) == SCS_INIT) |-> $past(init_cnt_ff) == 10'(INIT_CYCLES))
    else $error("init count wrong");
  a_uclk_late: assert property (@(posedge MCLK) disable iff (!rst_n)
    $rose(USER_INIT_CLOCK_ENABLED) |-> $past(tmr_ff) >= 32'(CD2CU_CYC))
    else $error("user clock enabled early");
  a_no_100_chain: assert property (@(posedge MCLK) disable iff (!rst_n)
    (CHAINED && CONFIG_CLOCK_OE && $changed(CONFIG_CLOCK_OUT)) |=> ($stable(CONFIG_CLOCK_OUT) || !CONFIG_CLOCK_OE))
    else $error("100 MHz used when chained");
  a_ps_capture: assert property (@(posedge MCLK) disable iff (!rst_n)
    ps_rise |=> sh_ff[0] == $past(cdat_s))
    else $error("data not captured on rise");
  a_as_capture: assert property (@(posedge MCLK) disable iff (!rst_n)
    as_fall |=> sh_ff[0] == $past(cdat_s))
    else $error("flash data not captured on fall");
  a_as_quiet: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!as_fall && !(CMD_READY && CMD_VALID)) |=> $stable(FLASH_COMMAND_OUT))
    else $error("command out moved off falling edge");
endmodule : scs_top
`default_nettype wire

// File: scs_cfg_partner.sv
// configuration host and serial flash stand-in for the sequencer bench
`timescale 1ns/100ps
`default_nettype none
module scs_cfg_partner
(
  input  wire logic status_wire,
  input  wire logic active,
  input  wire logic clk_wire,
  output var  logic host_clk,
  output logic      data_out
);
  logic host_d;
  logic flash_d;

  initial
  begin
    host_clk = 1'b0;
    host_d   = 1'b0;
    flash_d  = 1'b0;
  end

  // ****
  // passive host
  // ****
  task automatic wait_ready();
    wait (status_wire === 1'b1);
    #10000;
  endtask : wait_ready

  // msb first, clock parks low between frames
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      host_d = b[i];
      #31.2;
      host_clk = 1'b1;
      #62.5;
      host_clk = 1'b0;
      #31.3;
    end
    // line no longer holds the last bit once the frame is over
    host_d = ~b[0];
  endtask : send_byte

  // ****
  // flash: new bit after each rise, stable over the sampling fall
  // ****
  always @(posedge clk_wire)
    if (active)
      flash_d <= 1'($urandom_range(1, 0));

  assign data_out = active ? flash_d : host_d;
endmodule : scs_cfg_partner
`default_nettype wire

// File: test_serial_config_sequencer.sv
// self-checking bench for the serial configuration sequencer
`timescale 1ns/100ps
`default_nettype none
module test_serial_config_sequencer;
  import scs_pkg::*;
  localparam int ST_CYC = 20;
  localparam int UM_CYC = 4900;
  logic       mclk, nrst, req_n, ass, uice, chained, uic, cmd_valid, load_done, ready;
  logic [1:0] clk_sel;
  logic [7:0] cmd_data;
  logic       status_oe, status_out, conf_done, user_mode, cclk_out, cclk_oe, fco, uic_en;
  logic       cmd_ready, byte_valid, host_clk, data_w;
  logic [7:0] cfg_byte;
  wire logic  status_wire = status_oe ? status_out : 1'b1;
  wire logic  clk_wire    = cclk_oe ? cclk_out : host_clk;
  int         fail_count, n_tests, per_n, per_last, bits, uc_n, n, n1;
  logic       pclk, pfco, arm, cap_on;
  logic [7:0] sh, b, fsh;
  logic [7:0] exp_q[$];

  scs_top #(.STATUS_CYC(ST_CYC), .CD2UM_CYC(UM_CYC)) dut (
    .MCLK(mclk), .NRST(nrst), .CFG_REQ_N(req_n), .STATUS_N_IN(status_wire),
    .STATUS_N_OE(status_oe), .STATUS_N_OUT(status_out), .CONF_DONE(conf_done),
    .USER_MODE(user_mode), .ACTIVE_SERIAL_SCHEME(ass), .USER_INIT_CLOCK_EN(uice),
    .CHAINED(chained), .CLK_SEL(clk_sel), .CONFIG_CLOCK_IN(clk_wire),
    .CONFIG_CLOCK_OUT(cclk_out), .CONFIG_CLOCK_OE(cclk_oe), .CONFIG_DATA_IN(data_w),
    .FLASH_COMMAND_OUT(fco), .USER_INIT_CLOCK(uic), .USER_INIT_CLOCK_ENABLED(uic_en),
    .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .LOAD_DONE(load_done), .CFG_BYTE(cfg_byte), .CFG_BYTE_VALID(byte_valid),
    .CFG_BYTE_READY(ready));

  scs_cfg_partner partner (.status_wire(status_wire), .active(ass), .clk_wire(clk_wire),
    .host_clk(host_clk), .data_out(data_w));

  // ****
  // clocks and checking helpers
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    uic = 1'b0;
    forever #20 uic = ~uic;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("counts: %0d compared, %0d mismatched", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // sel: 0 status drive, 1 config done, 2 user mode, 3 user clock enabled
  task automatic wait_lvl(input int sel, input logic v, output int cnt);
    logic [3:0] s;
    cnt = 0;
    do
    begin
      @(negedge mclk);
      cnt++;
      s = {uic_en, user_mode, conf_done, status_oe};
    end while (s[sel] !== v && cnt < 20000);
    if (s[sel] !== v)
      fail_count++;
  endtask : wait_lvl

  task automatic send_cmd(input logic [7:0] c);
    int k;
    k = 0;
    // start just after a rise so that no fall coincides with the load
    @(posedge cclk_out);
    @(negedge mclk);
    cmd_data  = c;
    cmd_valid = 1'b1;
    do
      @(posedge mclk);
    while (cmd_ready !== 1'b1 && ++k < 1000);
    @(negedge mclk);
    cmd_valid = 1'b0;
    bits      = 0;
    cap_on    = 1'b0;
    arm       = 1'b1;
    k         = 0;
    while (bits < 8 && ++k < 2000)
      @(negedge mclk);
    chk(sh, c);
    chk(dut.sh_ff, fsh);
  endtask : send_cmd

  // ****
  // monitors: received bytes, generated clock and command line
  // ****
  always @(posedge mclk)
    if (byte_valid === 1'b1 && ready === 1'b1 && ass === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk(1'b1, 1'b0);
      else
        chk(cfg_byte, exp_q.pop_front());
    end

  always @(posedge uic)
    if (uic_en === 1'b1 && user_mode !== 1'b1)
      uc_n++;

  always @(negedge mclk)
  begin
    per_n++;
    if (cclk_oe === 1'b1 && pfco !== fco)
      chk(pclk & ~cclk_out, 1'b1);
    if (pclk === 1'b0 && cclk_out === 1'b1)
    begin
      per_last = per_n;
      per_n    = 0;
      if (cap_on && bits < 8)
      begin
        sh = {sh[6:0], fco};
        bits++;
      end
    end
    if (pclk === 1'b1 && cclk_out === 1'b0)
    begin
      fsh = {fsh[6:0], data_w};
      if (arm)
      begin
        arm    = 1'b0;
        cap_on = 1'b1;
      end
    end
    pclk = cclk_out;
    pfco = fco;
  end

  initial
  begin
    #300000;
    fail_count++;
    print_verdict();
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    {nrst, ass, uice, chained, cmd_valid, load_done, ready, arm, cap_on} = '0;
    {req_n, pclk, pfco, clk_sel, cmd_data, sh} = {1'b1, 2'b00, 2'h0, 8'h00, 8'h00};
    {fail_count, n_tests, per_n, per_last, bits, uc_n} = '0;
    void'($urandom(85));
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    wait_lvl(0, 1'b0, n);
    chk(32'(n >= ST_CYC && n <= STATUS_MAX_CYC), 1);
    $display("test reset release done");
    // fifo is filled while the consumer stalls, then drained
    partner.wait_ready();
    for (int i = 0; i < 8; i++)
    begin
      b = 8'($urandom);
      exp_q.push_back(b);
      partner.send_byte(b);
      if (i == 3)
      begin
        repeat (20) @(negedge mclk);
        ready = 1'b1;
      end
    end
    repeat (20) @(negedge mclk);
    chk(exp_q.size(), 0);
    load_done = 1'b1;
    wait_lvl(1, 1'b1, n);
    load_done = 1'b0;
    wait_lvl(2, 1'b1, n);
    chk(32'(n >= UM_CYC && n <= CD2UM_MAX_US * CLK_MHZ), 1);
    $display("test passive load done");
    // restart from user mode into the active scheme with the user clock
    ass   = 1'b1;
    uice  = 1'b1;
    req_n = 1'b0;
    wait_lvl(0, 1'b1, n1);
    wait_lvl(1, 1'b0, n);
    chk(32'(n1 <= CF2ST0_CYC), 1);
    chk(32'(n1 + n <= CF2CD_CYC), 1);
    chk(user_mode, 1'b0);
    repeat (200) @(negedge mclk);
    req_n = 1'b1;
    wait_lvl(0, 1'b0, n);
    chk(32'(n <= STATUS_MAX_CYC), 1);
    $display("test restart handshake done");
    for (int i = 0; i < 5; i++)
    begin
      clk_sel = (i == 4) ? 2'h3 : 2'(i);
      chained = (i == 4);
      repeat (80) @(negedge mclk);
      chk(per_last, (i == 4) ? 4 : 16 >> i);
    end
    chained = 1'b0;
    clk_sel = 2'h0;
    send_cmd(8'($urandom));
    clk_sel = 2'h2;
    ready   = 1'b0;
    repeat (400) @(negedge mclk);
    n = per_n;
    repeat (100) @(negedge mclk);
    chk(32'(per_n - n == 100), 1);
    ready = 1'b1;
    repeat (100) @(negedge mclk);
    $display("test active clock done");
    load_done = 1'b1;
    wait_lvl(1, 1'b1, n);
    load_done = 1'b0;
    wait_lvl(3, 1'b1, n);
    chk(32'(n >= CD2CU_CYC), 1);
    wait_lvl(2, 1'b1, n);
    chk(32'(uc_n >= INIT_CYCLES && uc_n <= INIT_CYCLES + 2), 1);
    $display("test user clock init done");
    print_verdict();
  end
endmodule : test_serial_config_sequencer
`default_nettype wire
